/* rtl/plcdtp_debounce.sv */
// debouncer and synchroniser for one opto input
`timescale 1ns/1ps
`default_nettype none
module plcdtp_debounce
    import plcdtp_pkg::*;
#(
    parameter int unsigned COUNT = DEBOUNCE_CYC
) (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic raw_in,
    output logic      clean_q
);
    localparam int unsigned CW = $clog2(COUNT + 1);
    logic          meta_q;
    logic          sync_q;
    logic [CW-1:0] cnt_q;
    wire           differs  = (sync_q != clean_q);
    wire           expired  = (cnt_q == CW'(COUNT - 1));

    always_ff @(posedge mclk) begin
        meta_q <= raw_in;
        sync_q <= meta_q;
    end

    // level must hold a full interval before it is taken
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_q   <= '0;
            clean_q <= 1'b0;
        end else if (!differs) begin
            cnt_q   <= '0;
        end else if (expired) begin
            cnt_q   <= '0;
            clean_q <= sync_q;
        end else begin
            cnt_q   <= cnt_q + CW'(1);
        end
    end
endmodule // plcdtp_debounce
`default_nettype wire

/* rtl/plcdtp_port.sv */
// discrete control port logic of the tester
`timescale 1ns/1ps
`default_nettype none
module plcdtp_port
    import plcdtp_pkg::*;
#(
    parameter int unsigned DEBOUNCE_COUNT = DEBOUNCE_CYC
) (
    input  wire logic                   mclk,
    input  wire logic                   srst,
    input  wire logic                   control_request_in,
    input  wire logic                   measure_discharge_pin,
    input  wire logic                   bank_select_in,
    input  wire logic [MEM_BITS-1:0]    memory_select_in,
    input  wire logic                   analogue_io_channel_a,
    input  wire logic                   analogue_input_channel_c,
    input  wire logic                   test_done,
    input  wire logic                   test_pass,
    input  wire logic                   test_error,
    output logic                        control_granted_out,
    output logic                        test_finished_out,
    output logic                        result_pass_out,
    output logic                        result_fail_out,
    output logic                        error_out,
    output logic                        run_sequence_q,
    output logic                        discharge_q,
    output logic                        launch_q,
    output logic [MEMNUM_BITS-1:0]      sequence_number_q
);
    logic [NUM_INPUTS-1:0] raw_in;
    logic [NUM_INPUTS-1:0] clean;
    logic                  meas_prev_q;
    logic                  ext_ctrl_q;
    logic                  measured_q;
    plcdtp_state_e         state_q;
    plcdtp_state_e         state_d;

    // inputs read as plain logic levels
    assign raw_in[MEM_BITS-1:0] = memory_select_in;
    assign raw_in[IDX_REQ]      = control_request_in;
    assign raw_in[IDX_BANK]     = bank_select_in;
    assign raw_in[IDX_MEAS]     = measure_discharge_pin;

    generate
        for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
            plcdtp_debounce #(.COUNT(DEBOUNCE_COUNT)) u_db (
                .mclk    (mclk),
                .srst    (srst),
                .raw_in  (raw_in[i]),
                .clean_q (clean[i])
            );
        end
    endgenerate

    wire                   measure_in  = clean[IDX_MEAS];
    wire                   meas_rise   = measure_in & ~meas_prev_q;
    wire                   req_s       = clean[IDX_REQ];
    wire                   bank_s      = clean[IDX_BANK];
    wire [MEM_BITS-1:0]    mem_s       = clean[MEM_BITS-1:0];
    // binary number, bit 0 least significant
    wire [MEMNUM_BITS-1:0] mem_base    = {{(MEMNUM_BITS-MEM_BITS){1'b0}}, mem_s};
    wire [MEMNUM_BITS-1:0] mem_num     = bank_s ? mem_base : mem_base + BANK_OFFSET;
    // launch only under external control request
    wire                   start       = meas_rise & req_s;
    wire                   unused_ana  = analogue_io_channel_a ^ analogue_input_channel_c;
    // decoded state flags and the release event
    wire                   in_measure  = (state_q == PLCDTP_MEASURE);
    wire                   to_measure  = (state_d == PLCDTP_MEASURE);
    wire                   release_ev  = meas_rise & ~req_s;
    // test done counts only while measuring
    wire                   finish_ev   = test_done & in_measure;
    wire                   first_done  = finish_ev & ext_ctrl_q;
    wire                   pass_d      = test_pass & ~test_error;
    wire                   fail_d      = ~test_pass | test_error;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PLCDTP_IDLE: begin
                if (start) state_d = PLCDTP_MEASURE;
            end
            PLCDTP_MEASURE: begin
                if (!measure_in) state_d = PLCDTP_DISCH;
            end
            PLCDTP_DISCH: begin
                if (start) state_d = PLCDTP_MEASURE;
                else if (meas_rise) state_d = PLCDTP_IDLE;
            end
            default: state_d = PLCDTP_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= PLCDTP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            meas_prev_q <= 1'b0;
        end else begin
            meas_prev_q <= measure_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            launch_q <= 1'b0;
        end else begin
            launch_q <= start;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ext_ctrl_q <= 1'b0;
        end else if (meas_rise) begin
            ext_ctrl_q <= req_s;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            sequence_number_q <= '0;
        end else if (start) begin
            sequence_number_q <= mem_num;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            run_sequence_q <= 1'b0;
        end else begin
            run_sequence_q <= to_measure;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            discharge_q <= 1'b1;
        end else begin
            discharge_q <= ~to_measure;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            measured_q <= 1'b0;
        end else if (release_ev) begin
            measured_q <= 1'b0;
        end else if (first_done) begin
            measured_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            control_granted_out <= 1'b0;
        end else if (release_ev) begin
            control_granted_out <= 1'b0;
        end else begin
            control_granted_out <= measured_q | first_done;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            test_finished_out <= 1'b0;
        end else if (start) begin
            test_finished_out <= 1'b0;
        end else if (finish_ev) begin
            test_finished_out <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            result_pass_out <= 1'b0;
        end else if (start) begin
            result_pass_out <= 1'b0;
        end else if (finish_ev) begin
            result_pass_out <= pass_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            result_fail_out <= 1'b0;
        end else if (start) begin
            result_fail_out <= 1'b0;
        end else if (finish_ev) begin
            result_fail_out <= fail_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            error_out <= 1'b0;
        end else if (start) begin
            error_out <= 1'b0;
        end else if (finish_ev) begin
            error_out <= test_error;
        end
    end
endmodule // plcdtp_port
`default_nettype wire

/* shared/plcdtp_pkg.sv */
// constants for the discrete test control port
package plcdtp_pkg;
    localparam int unsigned MCLK_HZ       = 250_000_000;
    localparam int unsigned DEBOUNCE_US   = 1000;
    localparam int unsigned DEBOUNCE_CYC  = (MCLK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam int unsigned MEM_BITS      = 8;
    localparam int unsigned MEMNUM_BITS   = 10;
    localparam logic [MEMNUM_BITS-1:0] BANK_OFFSET = 10'h100;
    localparam int unsigned NUM_INPUTS    = 11;
    localparam int unsigned IDX_REQ       = 8;
    localparam int unsigned IDX_BANK      = 9;
    localparam int unsigned IDX_MEAS      = 10;

    typedef enum logic [1:0] {
        PLCDTP_IDLE    = 2'b00,
        PLCDTP_MEASURE = 2'b01,
        PLCDTP_DISCH   = 2'b10
    } plcdtp_state_e;
endpackage : plcdtp_pkg

/* verif/plcdtp_plc.sv */
// controller model driving the opto inputs
`timescale 1ns/1ps
`default_nettype none
module plcdtp_plc (
    input  wire logic       mclk,
    input  wire logic       meas_cmd,
    input  wire logic       req_cmd,
    input  wire logic       bank_cmd,
    input  wire logic [7:0] sel_cmd,
    output logic            req_pin,
    output logic            meas_pin,
    output logic            bank_pin,
    output logic [7:0]      sel_pin
);
    logic [10:0] cmd_q;
    // commands taken at the rising edge, away from the bench's falling edge
    always @(posedge mclk) begin
        cmd_q <= {req_cmd, meas_cmd, bank_cmd, sel_cmd};
    end
    always @(negedge mclk) begin
        {req_pin, meas_pin, bank_pin, sel_pin} <= cmd_q;
    end
endmodule // plcdtp_plc
`default_nettype wire

/* verif/plcdtp_props.sv */
// concurrent checks on the control port outputs
`timescale 1ns/1ps
`default_nettype none
module plcdtp_props
    import plcdtp_pkg::*;
(
    input wire logic                   mclk,
    input wire logic                   srst,
    input wire logic                   test_done,
    input wire logic                   test_pass,
    input wire logic                   test_error,
    input wire logic                   control_granted_out,
    input wire logic                   test_finished_out,
    input wire logic                   result_pass_out,
    input wire logic                   result_fail_out,
    input wire logic                   error_out,
    input wire logic                   run_sequence_q,
    input wire logic                   discharge_q,
    input wire logic                   launch_q,
    input wire logic [MEMNUM_BITS-1:0] sequence_number_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    property p_excl; !(result_pass_out && result_fail_out); endproperty
    a_excl: assert property (p_excl) else $error("pass with fail");
    property p_clr; launch_q |-> !result_pass_out && !result_fail_out && !test_finished_out; endproperty
    a_clr: assert property (p_clr) else $error("results not cleared");
    property p_meas; launch_q |-> run_sequence_q && !discharge_q; endproperty
    a_meas: assert property (p_meas) else $error("launch not measuring");
    property p_pulse; launch_q |=> !launch_q; endproperty
    a_pulse: assert property (p_pulse) else $error("launch too long");
    property p_hold; !launch_q |-> $stable(sequence_number_q); endproperty
    a_hold: assert property (p_hold) else $error("number moved");
    property p_fail; test_done && run_sequence_q && test_error |=> result_fail_out && error_out; endproperty
    a_fail: assert property (p_fail) else $error("error not failed");
    property p_pass; test_done && run_sequence_q && test_pass && !test_error |=> result_pass_out && test_finished_out; endproperty
    a_pass: assert property (p_pass) else $error("pass missing");
    property p_grant; $rose(control_granted_out) |-> $past(test_done); endproperty
    a_grant: assert property (p_grant) else $error("grant without test");
endmodule // plcdtp_props
bind plcdtp_port plcdtp_props u_props (.mclk, .srst, .test_done, .test_pass, .test_error, .control_granted_out,
    .test_finished_out, .result_pass_out, .result_fail_out, .error_out, .run_sequence_q, .discharge_q,
    .launch_q, .sequence_number_q);
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the control port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import plcdtp_pkg::*;
    logic        mclk, srst, req, meas, bank, an_a, an_c, done, pass, err, fin_d;
    logic        rq_p, ms_p, bk_p, grant, fin, rp, rf, eo, run, dis, launch;
    logic [7:0]  sel, sl_p;
    logic [9:0]  seqn, exp_q[$], res_q[$];
    logic [31:0] rng = 32'h12;
    int          bad_count, total_checks, cyc;
    plcdtp_plc u_plc (.mclk, .meas_cmd(meas), .req_cmd(req), .bank_cmd(bank), .sel_cmd(sel),
        .req_pin(rq_p), .meas_pin(ms_p), .bank_pin(bk_p), .sel_pin(sl_p));
    plcdtp_port #(.DEBOUNCE_COUNT(4)) u_dut (.mclk, .srst, .control_request_in(rq_p),
        .measure_discharge_pin(ms_p), .bank_select_in(bk_p), .memory_select_in(sl_p),
        .analogue_io_channel_a(an_a), .analogue_input_channel_c(an_c), .test_done(done),
        .test_pass(pass), .test_error(err), .control_granted_out(grant), .test_finished_out(fin),
        .result_pass_out(rp), .result_fail_out(rf), .error_out(eo), .run_sequence_q(run),
        .discharge_q(dis), .launch_q(launch), .sequence_number_q(seqn));
    task automatic check(string nm, logic [9:0] seen, logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [31:0] xs(logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic [9:0] pop(ref logic [9:0] q[$]);
        return q.size() ? q.pop_front() : 10'h3FF;
    endfunction
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        fin_d <= fin;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
        if (launch === 1'b1) check("number", seqn, pop(exp_q));
        if (fin === 1'b1 && fin_d === 1'b0) check("results", {7'h00, eo, rp, rf}, pop(res_q));
    end
    task automatic run_test(logic [7:0] s, logic b, logic p, logic e);
        {sel, bank, req} = {s, b, 1'b1};
        exp_q.push_back(b ? {2'b00, s} : {2'b00, s} + BANK_OFFSET);
        res_q.push_back({7'h00, e, p & ~e, ~p | e});
        repeat (12) @(negedge mclk);
        meas = 1'b1;
        for (int i = 0; i < 40 && run !== 1'b1; i++) @(negedge mclk);
        {sel, bank, req} = {~s, ~b, 1'b0};
        repeat (12) @(negedge mclk);
        {done, pass, err} = {1'b1, p, e};
        @(negedge mclk) done = 1'b0;
        repeat (2) @(negedge mclk);
        check("granted", {9'h000, grant}, 10'h001);
        meas = 1'b0;
        for (int i = 0; i < 40 && dis !== 1'b1; i++) @(negedge mclk);
        check("discharge", {8'h00, run, dis}, 10'h001);
        {done, pass, err} = {1'b1, ~p, ~e};
        @(negedge mclk) done = 1'b0;
        repeat (2) @(negedge mclk);
        check("stand", {7'h00, eo, rp, rf}, {7'h00, e, p & ~e, ~p | e});
    endtask
    initial begin
        {req, meas, bank, an_a, an_c, done, pass, err, sel} = 16'h0000;
        srst = 1'b1;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        {req, meas} = 2'b11;
        @(negedge mclk) meas = 1'b0;
        repeat (20) @(negedge mclk);
        run_test(8'hFF, 1'b0, 1'b1, 1'b0);
        run_test(8'h00, 1'b1, 1'b0, 1'b0);
        run_test(8'h81, 1'b0, 1'b1, 1'b1);
        repeat (5) begin
            rng = xs(rng);
            {an_a, an_c} = rng[13:12];
            run_test(rng[7:0], rng[8], rng[9], rng[10] & rng[11]);
        end
        repeat (12) @(negedge mclk);
        meas = 1'b1;
        repeat (30) @(negedge mclk);
        check("release", {grant, run, 7'h00, exp_q.size() == 0}, 10'h001);
        complete_run();
    end
endmodule // tb
`default_nettype wire
